// ### src/lsc_cfg.svh
// Constants of the low-speed control link: timing, address, maps, fields.
// Assumes a 20 MHz reference clock on both ends.
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH
// Reference clock rate
`define LSC_CLK_MHZ 20
// Seven-bit two-wire address of the module
`define LSC_DEV_ADDR 7'h50
// Quarter of a serial clock period, made by the host divider
`define LSC_QTR_NS 250
`define LSC_QTR_CYC ((`LSC_QTR_NS * `LSC_CLK_MHZ) / 1000)
// Least reset pulse, rounded up to whole cycles
`define LSC_RST_MIN_NS 10000
`define LSC_RST_MIN_CYC ((`LSC_RST_MIN_NS * `LSC_CLK_MHZ + 999) / 1000)
// Initialization time after power-up or reset
`define LSC_INIT_MS 2000
`define LSC_INIT_CYC (`LSC_INIT_MS * `LSC_CLK_MHZ * 1000)
// Module memory map offsets
`define LSC_MAP_STATUS 8'h00
`define LSC_MAP_FLAGS 8'h01
`define LSC_MAP_CLEAR 8'h02
`define LSC_MAP_ENABLE 8'h03
`define LSC_MAP_USER 8'h04
// Module field positions and reset values
`define LSC_ST_PEND 0
`define LSC_ST_LP 1
`define LSC_FL_DONE 0
`define LSC_FL_FAULT 1
`define LSC_EN_RST 2'h3
// Host register offsets
`define LSC_H_CMD 4'h0
`define LSC_H_REG 4'h1
`define LSC_H_WDATA 4'h2
`define LSC_H_PINS 4'h3
`define LSC_H_STAT 4'h4
`define LSC_H_RDATA 4'h5
`define LSC_H_IRQ 4'h6
`define LSC_H_ICLR 4'h7
`define LSC_H_IEN 4'h8
// Host field positions and reset values
`define LSC_CMD_GO 0
`define LSC_CMD_RD 1
`define LSC_PIN_SEL 0
`define LSC_PIN_RST 1
`define LSC_PIN_LP 2
`define LSC_PINS_RST 3'h6
`define LSC_IRQ_DONE 0
`define LSC_IRQ_NACK 1
`define LSC_IRQ_INT 2
`define LSC_IRQ_PRS 3
`endif

// ### src/lsc_pkg.sv
// Types of the low-speed control link: state enums and state structs.
// Assumes nothing beyond the tool's SystemVerilog support.
package lsc_pkg;
   typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK} lsc_dev_e;
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_START, H_BIT, H_STOP}
      lsc_host_e;
   // Module state: sync stages index 0 clock,1 data,2 select,3 reset,4 lp
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] f;
      logic [4:0] fp;
      lsc_dev_e st;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic [1:0] nbyte;
      logic rw;
      logic [7:0] ptr;
      logic sda_oe;
      logic [7:0] rst_cnt;
      logic pend;
      logic [25:0] init_cnt;
      logic [1:0] flags;
      logic [1:0] en;
      logic [3:0][7:0] user;
   } lsc_dev_s;
   // Host state: sync stages index 0 data,1 interrupt,2 present
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] f;
      logic [2:0] fp;
      lsc_host_e st;
      logic [2:0] qc;
      logic [1:0] ph;
      logic [3:0] bitc;
      logic [1:0] nb;
      logic ph2;
      logic rw;
      logic [7:0] sh;
      logic ack_bad;
      logic scl_oe;
      logic sda_oe;
      logic nack;
      logic [7:0] reg_a;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [2:0] pins;
      logic [3:0] irq;
      logic [3:0] ien;
      logic [7:0] rd_q;
   } lsc_host_s;
endpackage

// ### src/lsc_link_if.sv
// Pins between host board and module, with pull-ups resolved here.
// Assumes open-drain pins: a driver only ever pulls low.
`timescale 1ns/1ps
interface lsc_link_if;
   logic scl_o;
   logic scl_oe;
   logic h_sda_o;
   logic h_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic int_o;
   logic int_oe;
   logic prs_o;
   logic prs_oe;
   logic module_select_n;
   logic module_reset_n;
   logic low_power_select;
   logic scl;
   logic sda;
   logic interrupt_n;
   logic module_present_n;
   // Pull-up wins unless an enabled driver pulls low
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
   assign interrupt_n = ~(int_oe & ~int_o);
   assign module_present_n = ~(prs_oe & ~prs_o);
   modport dev (
      input scl, sda, module_select_n, module_reset_n, low_power_select,
      output d_sda_o, d_sda_oe, int_o, int_oe, prs_o, prs_oe
   );
   modport host (
      output scl_o, scl_oe, h_sda_o, h_sda_oe,
      output module_select_n, module_reset_n, low_power_select,
      input sda, interrupt_n, module_present_n
   );
endinterface

// ### src/lsc_module.sv
// Module end of the low-speed control link: two-wire slave, memory map,
// reset and power-up handshake, interrupt and presence pins.
// Assumes the host makes the serial clock; all pins are sampled here.
`timescale 1ns/1ps
`include "lsc_cfg.svh"
module lsc_module #(
   parameter int unsigned INIT_CYC = `LSC_INIT_CYC
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RSTN_I,
   // Pins toward the host
   lsc_link_if.dev LNK,
   // User side
   input wire logic FAULT_I,
   output logic LOW_POWER_O,
   output logic INIT_PENDING_O,
   output logic [31:0] SETTINGS_O
);
   localparam lsc_pkg::lsc_dev_s DEV_RST = '{
      s1: 5'h1f, s2: 5'h1f, s3: 5'h1f, f: 5'h1f, fp: 5'h1f,
      st: lsc_pkg::D_IDLE, pend: 1'b1, en: `LSC_EN_RST, default: '0
   };

   lsc_pkg::lsc_dev_s dev_reg;
   lsc_pkg::lsc_dev_s dev_next;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic long_reset;

   // Map read; used for the first and each following byte of a read
   function automatic logic [7:0] map_read(input lsc_pkg::lsc_dev_s s,
                                           input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == `LSC_MAP_STATUS) begin
         v[`LSC_ST_PEND] = s.pend;
         v[`LSC_ST_LP] = s.f[4];
      end else if (a == `LSC_MAP_FLAGS) begin
         v[1:0] = s.flags;
      end else if (a == `LSC_MAP_ENABLE) begin
         v[1:0] = s.en;
      end else if (a[7:2] == `LSC_MAP_USER >> 2) begin
         v = s.user[a[1:0]];
      end
      return v;
   endfunction

   // Edges and conditions of the filtered pins
   assign scl_rise = dev_reg.f[0] & ~dev_reg.fp[0];
   assign scl_fall = ~dev_reg.f[0] & dev_reg.fp[0];
   assign bus_start = dev_reg.f[0] & dev_reg.fp[0] &
                      dev_reg.fp[1] & ~dev_reg.f[1];
   assign bus_stop = dev_reg.f[0] & dev_reg.fp[0] &
                     ~dev_reg.fp[1] & dev_reg.f[1];
   assign long_reset = dev_reg.rst_cnt == 8'(`LSC_RST_MIN_CYC);

   // Next state of the whole module
   always_comb begin
      dev_next = dev_reg;
      // Three stages; a pin counts once stages two and three agree
      dev_next.s1 = {LNK.low_power_select, LNK.module_reset_n,
                     LNK.module_select_n, LNK.sda, LNK.scl};
      dev_next.s2 = dev_reg.s1;
      dev_next.s3 = dev_reg.s2;
      for (int i = 0; i < 5; i++) begin
         if (dev_reg.s2[i] == dev_reg.s3[i]) begin
            dev_next.f[i] = dev_reg.s3[i];
         end
      end
      dev_next.fp = dev_reg.f;

      // Serial slave; deselect or stop drops the transfer at once
      if (dev_reg.f[2] || bus_stop) begin
         dev_next.st = lsc_pkg::D_IDLE;
         dev_next.sda_oe = 1'b0;
      end else if (bus_start) begin
         dev_next.st = lsc_pkg::D_RX;
         dev_next.bitc = 4'h0;
         dev_next.nbyte = 2'h0;
         dev_next.sda_oe = 1'b0;
      end else begin
         case (dev_reg.st)
            lsc_pkg::D_RX: begin
               if (scl_rise) begin
                  dev_next.sh = {dev_reg.sh[6:0], dev_reg.f[1]};
                  dev_next.bitc = dev_reg.bitc + 4'h1;
               end
               if (scl_fall && dev_reg.bitc == 4'h8) begin
                  dev_next.st = lsc_pkg::D_ACK;
                  dev_next.sda_oe = 1'b1;
                  if (dev_reg.nbyte == 2'h0) begin
                     // Foreign address: stay silent until next start
                     dev_next.rw = dev_reg.sh[0];
                     if (dev_reg.sh[7:1] != `LSC_DEV_ADDR) begin
                        dev_next.st = lsc_pkg::D_IDLE;
                        dev_next.sda_oe = 1'b0;
                     end
                  end else if (dev_reg.nbyte == 2'h1) begin
                     dev_next.ptr = dev_reg.sh;
                  end else begin
                     dev_next.ptr = dev_reg.ptr + 8'h01;
                     if (dev_reg.ptr == `LSC_MAP_CLEAR) begin
                        dev_next.flags = dev_reg.flags & ~dev_reg.sh[1:0];
                     end else if (dev_reg.ptr == `LSC_MAP_ENABLE) begin
                        dev_next.en = dev_reg.sh[1:0];
                     end else if (dev_reg.ptr[7:2] ==
                                  `LSC_MAP_USER >> 2) begin
                        dev_next.user[dev_reg.ptr[1:0]] = dev_reg.sh;
                     end
                  end
               end
            end
            lsc_pkg::D_ACK: begin
               // Acknowledge held low through the ninth clock
               if (scl_fall) begin
                  dev_next.bitc = 4'h0;
                  if (dev_reg.rw) begin
                     dev_next.sh = map_read(dev_reg, dev_reg.ptr);
                     dev_next.sda_oe = ~dev_next.sh[7];
                     dev_next.ptr = dev_reg.ptr + 8'h01;
                     dev_next.st = lsc_pkg::D_TX;
                  end else begin
                     dev_next.sda_oe = 1'b0;
                     dev_next.st = lsc_pkg::D_RX;
                     if (dev_reg.nbyte != 2'h2) begin
                        dev_next.nbyte = dev_reg.nbyte + 2'h1;
                     end
                  end
               end
            end
            lsc_pkg::D_TX: begin
               if (scl_rise) begin
                  dev_next.bitc = dev_reg.bitc + 4'h1;
               end
               if (scl_fall) begin
                  if (dev_reg.bitc == 4'h8) begin
                     dev_next.sda_oe = 1'b0;
                     dev_next.st = lsc_pkg::D_TXACK;
                  end else begin
                     dev_next.sh = {dev_reg.sh[6:0], 1'b0};
                     dev_next.sda_oe = ~dev_reg.sh[6];
                  end
               end
            end
            lsc_pkg::D_TXACK: begin
               // No acknowledge ends the read; wait for stop
               if (scl_rise) begin
                  if (dev_reg.f[1]) begin
                     dev_next.st = lsc_pkg::D_IDLE;
                  end else begin
                     dev_next.st = lsc_pkg::D_ACK;
                  end
               end
            end
            default: begin
               dev_next.sda_oe = 1'b0;
            end
         endcase
      end

      // Events set after the clear above, so a set wins
      if (FAULT_I) begin
         dev_next.flags[`LSC_FL_FAULT] = 1'b1;
      end
      if (dev_reg.pend) begin
         dev_next.init_cnt = dev_reg.init_cnt + 26'h1;
         if (dev_reg.init_cnt == 26'(INIT_CYC - 1)) begin
            dev_next.pend = 1'b0;
            dev_next.flags[`LSC_FL_DONE] = 1'b1;
         end
      end

      // Reset pin: count a low level, saturating at the least pulse
      if (dev_reg.f[3]) begin
         dev_next.rst_cnt = 8'h00;
      end else if (!long_reset) begin
         dev_next.rst_cnt = dev_reg.rst_cnt + 8'h01;
      end
      // Held in defaults while the pulse lasts; init starts at release
      if (long_reset) begin
         dev_next.st = lsc_pkg::D_IDLE;
         dev_next.sda_oe = 1'b0;
         dev_next.ptr = 8'h00;
         dev_next.pend = 1'b1;
         dev_next.init_cnt = 26'h0;
         dev_next.flags = 2'h0;
         dev_next.en = `LSC_EN_RST;
         dev_next.user = '0;
      end
   end

   // State register; power-up starts pending like a reset
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         dev_reg <= DEV_RST;
      end else begin
         dev_reg <= dev_next;
      end
   end

   // Pins: all open drain, only ever pulled low
   assign LNK.d_sda_o = 1'b0;
   assign LNK.d_sda_oe = dev_reg.sda_oe;
   assign LNK.int_o = 1'b0;
   assign LNK.int_oe = |(dev_reg.flags & dev_reg.en);
   assign LNK.prs_o = 1'b0;
   assign LNK.prs_oe = 1'b1;

   // User outputs
   assign LOW_POWER_O = dev_reg.f[4];
   assign INIT_PENDING_O = dev_reg.pend;
   assign SETTINGS_O = dev_reg.user;
endmodule

// ### src/lsc_host.sv
// Host end of the low-speed control link: register port for software,
// serial clock divider, two-wire master, pin control and interrupt.
// Assumes one module on the link and a 20 MHz reference clock.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "lsc_cfg.svh"
module lsc_host (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RSTN_I,
   // Register port
   input wire logic [3:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   output logic IRQ_O,
   // Pins toward the module
   lsc_link_if.host LNK
);
   lsc_pkg::lsc_host_s h_reg;
   lsc_pkg::lsc_host_s h_next;
   logic tick;
   logic busy;
   logic rx_byte;
   logic last_byte;

   // Byte to send at a given position of a transaction
   function automatic logic [7:0] tx_byte(input logic ph2,
      input logic [1:0] nb, input logic [7:0] ra, input logic [7:0] wd);
      logic [7:0] v;
      v = wd;
      if (nb == 2'h0) begin
         v = {`LSC_DEV_ADDR, ph2};
      end else if (nb == 2'h1) begin
         v = ra;
      end
      return v;
   endfunction

   // Divider and transaction shape
   assign tick = h_reg.qc == 3'(`LSC_QTR_CYC - 1);
   assign busy = h_reg.st != lsc_pkg::H_IDLE;
   assign rx_byte = h_reg.ph2 && h_reg.nb == 2'h1;
   assign last_byte = (h_reg.ph2 || h_reg.rw) ? h_reg.nb == 2'h1
                                              : h_reg.nb == 2'h2;

   always_comb begin
      h_next = h_reg;
      h_next.s1 = {LNK.module_present_n, LNK.interrupt_n, LNK.sda};
      h_next.s2 = h_reg.s1;
      h_next.s3 = h_reg.s2;
      for (int i = 0; i < 3; i++) begin
         if (h_reg.s2[i] == h_reg.s3[i]) begin
            h_next.f[i] = h_reg.s3[i];
         end
      end
      h_next.fp = h_reg.f;

      // Register port; writes to the command are ignored while busy
      h_next.rd_q = 8'h00;
      if (WR_I) begin
         if (ADDR_I == `LSC_H_CMD) begin
            if (!busy && WDATA_I[`LSC_CMD_GO]) begin
               h_next.st = lsc_pkg::H_SETUP;
               h_next.rw = WDATA_I[`LSC_CMD_RD];
               h_next.qc = 3'h0;
               h_next.ph = 2'h0;
               h_next.ph2 = 1'b0;
               h_next.nack = 1'b0;
            end
         end else if (ADDR_I == `LSC_H_REG) begin
            h_next.reg_a = WDATA_I;
         end else if (ADDR_I == `LSC_H_WDATA) begin
            h_next.wdata = WDATA_I;
         end else if (ADDR_I == `LSC_H_PINS) begin
            h_next.pins = WDATA_I[2:0];
         end else if (ADDR_I == `LSC_H_ICLR) begin
            h_next.irq = h_reg.irq & ~WDATA_I[3:0];
         end else if (ADDR_I == `LSC_H_IEN) begin
            h_next.ien = WDATA_I[3:0];
         end
      end else if (RD_I) begin
         if (ADDR_I == `LSC_H_REG) begin
            h_next.rd_q = h_reg.reg_a;
         end else if (ADDR_I == `LSC_H_WDATA) begin
            h_next.rd_q = h_reg.wdata;
         end else if (ADDR_I == `LSC_H_PINS) begin
            h_next.rd_q = {5'h00, h_reg.pins};
         end else if (ADDR_I == `LSC_H_STAT) begin
            h_next.rd_q = {4'h0, ~h_reg.f[1], ~h_reg.f[2], h_reg.nack, busy};
         end else if (ADDR_I == `LSC_H_RDATA) begin
            h_next.rd_q = h_reg.rdata;
         end else if (ADDR_I == `LSC_H_IRQ) begin
            h_next.rd_q = {4'h0, h_reg.irq};
         end else if (ADDR_I == `LSC_H_IEN) begin
            h_next.rd_q = {4'h0, h_reg.ien};
         end
      end

      // Bit engine: four quarter ticks per bit, start and stop
      if (busy) begin
         h_next.qc = tick ? 3'h0 : h_reg.qc + 3'h1;
      end
      if (busy && tick) begin
         h_next.ph = h_reg.ph + 2'h1;
         case (h_reg.st)
            lsc_pkg::H_SETUP: begin
               // Select settles through the module's synchroniser
               if (h_reg.ph == 2'h3) begin
                  h_next.st = lsc_pkg::H_START;
               end
            end
            lsc_pkg::H_START: begin
               if (h_reg.ph == 2'h1) begin
                  h_next.sda_oe = 1'b1;
               end else if (h_reg.ph == 2'h3) begin
                  h_next.scl_oe = 1'b1;
                  h_next.st = lsc_pkg::H_BIT;
                  h_next.bitc = 4'h0;
                  h_next.nb = 2'h0;
                  h_next.sh = tx_byte(h_reg.ph2, 2'h0, h_reg.reg_a,
                                      h_reg.wdata);
               end
            end
            lsc_pkg::H_BIT: begin
               case (h_reg.ph)
                  2'h0: h_next.sda_oe = ~rx_byte &
                                        h_reg.bitc != 4'h8 & ~h_reg.sh[7];
                  2'h1: h_next.scl_oe = 1'b0;
                  2'h2: begin
                     if (h_reg.bitc == 4'h8) begin
                        h_next.ack_bad = h_reg.f[0];
                     end else begin
                        h_next.sh = {h_reg.sh[6:0], h_reg.f[0]};
                     end
                  end
                  default: begin
                     h_next.scl_oe = 1'b1;
                     h_next.bitc = h_reg.bitc + 4'h1;
                     if (h_reg.bitc == 4'h8) begin
                        h_next.bitc = 4'h0;
                        if (!rx_byte && h_reg.ack_bad) begin
                           h_next.nack = 1'b1;
                           h_next.irq[`LSC_IRQ_NACK] = 1'b1;
                           h_next.st = lsc_pkg::H_STOP;
                        end else if (rx_byte) begin
                           h_next.rdata = h_reg.sh;
                           h_next.st = lsc_pkg::H_STOP;
                        end else if (last_byte) begin
                           h_next.st = lsc_pkg::H_STOP;
                        end else begin
                           h_next.nb = h_reg.nb + 2'h1;
                           h_next.sh = tx_byte(h_reg.ph2, h_reg.nb + 2'h1,
                                               h_reg.reg_a, h_reg.wdata);
                        end
                     end
                  end
               endcase
            end
            lsc_pkg::H_STOP: begin
               if (h_reg.ph == 2'h0) begin
                  h_next.sda_oe = 1'b1;
               end else if (h_reg.ph == 2'h1) begin
                  h_next.scl_oe = 1'b0;
               end else if (h_reg.ph == 2'h3) begin
                  h_next.sda_oe = 1'b0;
                  // Read: pointer set first, then a fresh read transfer
                  if (h_reg.rw && !h_reg.ph2 && !h_reg.nack) begin
                     h_next.ph2 = 1'b1;
                     h_next.st = lsc_pkg::H_START;
                  end else begin
                     h_next.st = lsc_pkg::H_IDLE;
                     h_next.irq[`LSC_IRQ_DONE] = 1'b1;
                  end
               end
            end
            default: begin
               h_next.st = lsc_pkg::H_IDLE;
            end
         endcase
      end

      // Line events; the interrupt edge is masked while the module is held in reset, the present edge is not
      if (h_reg.fp[1] && !h_reg.f[1] && h_reg.pins[`LSC_PIN_RST]) begin
         h_next.irq[`LSC_IRQ_INT] = 1'b1;
      end
      if (h_reg.fp[2] != h_reg.f[2]) begin
         h_next.irq[`LSC_IRQ_PRS] = 1'b1;
      end
   end

   // State register
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         h_reg <= '0;
         h_reg.s1 <= 3'h7;
         h_reg.s2 <= 3'h7;
         h_reg.s3 <= 3'h7;
         h_reg.f <= 3'h7;
         h_reg.fp <= 3'h7;
         h_reg.pins <= `LSC_PINS_RST;
      end else begin
         h_reg <= h_next;
      end
   end

   // Pins; select held low for the whole transaction
   assign LNK.scl_o = 1'b0;
   assign LNK.scl_oe = h_reg.scl_oe;
   assign LNK.h_sda_o = 1'b0;
   assign LNK.h_sda_oe = h_reg.sda_oe;
   assign LNK.module_select_n = ~(busy | h_reg.pins[`LSC_PIN_SEL]);
   assign LNK.module_reset_n = h_reg.pins[`LSC_PIN_RST];
   assign LNK.low_power_select = h_reg.pins[`LSC_PIN_LP];

   // Software side
   assign RDATA_O = h_reg.rd_q;
   assign IRQ_O = |(h_reg.irq & h_reg.ien);
endmodule

// ### tb/lsc_link_checker.sv
// Checker of the pins between host end and module end.
// Assumes one link instance, sampled on the host clock.
`timescale 1ns/1ps
module lsc_link_checker (
   // Clock and reset
   input logic REF_CLK_I,
   input logic RSTN_I,
   // Link pins
   input logic scl,
   input logic scl_oe,
   input logic d_sda_o,
   input logic d_sda_oe,
   input logic int_o,
   input logic int_oe,
   input logic prs_o,
   input logic prs_oe,
   input logic module_select_n,
   input logic module_reset_n
);
   logic [8:0] low_cnt_reg;
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);
   // Low time of the reset pin; margin covers sync and filter
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I)
         low_cnt_reg <= 9'h000;
      else if (module_reset_n)
         low_cnt_reg <= 9'h000;
      else if (low_cnt_reg != 9'h1ff)
         low_cnt_reg <= low_cnt_reg + 9'h001;
   end
   property p_int_od; int_oe |-> !int_o; endproperty
   property p_sda_od; d_sda_oe |-> !d_sda_o; endproperty
   property p_prs_low; 1'b1 |-> prs_oe && !prs_o; endproperty
   property p_sel_idle; module_select_n [*8] |-> !d_sda_oe; endproperty
   property p_sda_chg; $changed(d_sda_oe) |-> !scl; endproperty
   property p_sel_setup; $fell(module_select_n) |-> !scl_oe [*8];
   endproperty
   property p_rst_int; low_cnt_reg >= 9'd215 |-> !int_oe; endproperty
   property p_rst_bus; low_cnt_reg >= 9'd215 |-> !d_sda_oe; endproperty
   a_int_od: assert property (p_int_od)
      else $error("interrupt pin driven high");
   a_sda_od: assert property (p_sda_od)
      else $error("data pin driven high");
   a_prs_low: assert property (p_prs_low)
      else $error("present pin not pulled low");
   a_sel_idle: assert property (p_sel_idle)
      else $error("module drives data while not selected");
   a_sda_chg: assert property (p_sda_chg)
      else $error("module data changed while clock high");
   a_sel_setup: assert property (p_sel_setup)
      else $error("clock started too soon after select");
   a_rst_int: assert property (p_rst_int)
      else $error("interrupt held through long reset");
   a_rst_bus: assert property (p_rst_bus)
      else $error("data driven through long reset");
   c_int: cover property ($rose(int_oe));
   c_ack: cover property ($rose(d_sda_oe));
   c_rst: cover property (low_cnt_reg == 9'd215);
endmodule

// ### tb/tb.sv
// Bench joining host end and module end over one link.
// Assumes a shortened init count; software speaks the host register port.
`timescale 1ns/1ps
module tb;
   logic clk, rstn, wr_en, rd_en, fault, irq, lp, pend;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, v;
   logic [31:0] sett;
   int n_errors = 0;
   int cmp_count = 0;
   lsc_link_if lnk ();
   lsc_module #(.INIT_CYC(50)) u_lsc_module (.REF_CLK_I(clk),
      .RSTN_I(rstn), .LNK(lnk), .FAULT_I(fault), .LOW_POWER_O(lp),
      .INIT_PENDING_O(pend), .SETTINGS_O(sett));
   lsc_host u_lsc_host (.REF_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr_en), .RD_I(rd_en), .RDATA_O(rdata),
      .IRQ_O(irq), .LNK(lnk));
   lsc_link_checker u_lsc_link_checker (.REF_CLK_I(clk), .RSTN_I(rstn),
      .scl(lnk.scl), .scl_oe(lnk.scl_oe), .d_sda_o(lnk.d_sda_o),
      .d_sda_oe(lnk.d_sda_oe), .int_o(lnk.int_o), .int_oe(lnk.int_oe),
      .prs_o(lnk.prs_o), .prs_oe(lnk.prs_oe),
      .module_select_n(lnk.module_select_n),
      .module_reset_n(lnk.module_reset_n));
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic test_done();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   // One serial transfer; busy is polled under a bound
   task automatic xfer(input logic [7:0] off, input logic [7:0] d,
      input logic [7:0] cmd);
      int i;
      reg_wr(4'h1, off);
      reg_wr(4'h2, d);
      reg_wr(4'h0, cmd);
      v = 8'h01;
      for (i = 0; i < 2000 && v[0] === 1'b1; i++)
         reg_rd(4'h4);
      chk(v[1:0], 2'b00);
      reg_rd(4'h5);
   endtask
   task automatic wait_init();
      int i;
      for (i = 0; i < 500 && pend !== 1'b0; i++)
         cyc(1);
      cyc(5);
   endtask
   // Watchdog well beyond the expected run
   initial begin
      cyc(40000);
      n_errors++;
      test_done();
   end
   initial begin
      rstn = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      fault = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      cyc(10);
      rstn <= 1'b1;
      wait_init();
      chk(lnk.interrupt_n, 1'b0);
      chk(lnk.module_present_n, 1'b0);
      reg_rd(4'h4);
      chk(v, 8'h0c);
      // Host interrupt: raise, mask, clear
      reg_wr(4'h8, 8'h04);
      cyc(2);
      chk(irq, 1'b1);
      reg_wr(4'h8, 8'h00);
      cyc(2);
      chk(irq, 1'b0);
      reg_wr(4'h7, 8'h0f);
      reg_wr(4'h8, 8'h04);
      cyc(2);
      chk(irq, 1'b0);
      xfer(8'h04, 8'ha5, 8'h01);
      chk(sett[7:0], 8'ha5);
      xfer(8'h07, 8'h3c, 8'h01);
      chk(sett[31:24], 8'h3c);
      xfer(8'h04, 8'h00, 8'h03);
      chk(v, 8'ha5);
      xfer(8'h00, 8'h00, 8'h03);
      chk(v, 8'h02);
      xfer(8'h01, 8'h00, 8'h03);
      chk(v, 8'h01);
      xfer(8'h02, 8'h01, 8'h01);
      chk(lnk.interrupt_n, 1'b1);
      @(posedge clk);
      fault <= 1'b1;
      @(posedge clk);
      fault <= 1'b0;
      cyc(10);
      chk(lnk.interrupt_n, 1'b0);
      xfer(8'h01, 8'h00, 8'h03);
      chk(v, 8'h02);
      reg_wr(4'h3, 8'h02);
      cyc(20);
      chk(lp, 1'b0);
      xfer(8'h00, 8'h00, 8'h03);
      chk(v, 8'h00);
      reg_rd(4'hf);
      chk(v, 8'h00);
      // Short reset pulse leaves settings alone
      reg_wr(4'h3, 8'h00);
      cyc(50);
      reg_wr(4'h3, 8'h02);
      cyc(20);
      chk(sett[7:0], 8'ha5);
      reg_wr(4'h3, 8'h00);
      cyc(230);
      chk(pend, 1'b1);
      chk(sett, 32'h0);
      chk(lnk.interrupt_n, 1'b1);
      // Traffic during a long reset must go unanswered
      reg_wr(4'h7, 8'h0f);
      reg_wr(4'h0, 8'h03);
      cyc(300);
      reg_rd(4'h4);
      chk(v, 8'h06);
      reg_rd(4'h6);
      chk(v, 8'h03);
      chk(irq, 1'b0);
      reg_wr(4'h3, 8'h06);
      wait_init();
      chk(lnk.interrupt_n, 1'b0);
      chk(lp, 1'b1);
      cyc(2);
      chk(irq, 1'b1);
      test_done();
   end
endmodule
